// ===== timer8_compare.sv
// Top of the 8-bit timer with two output-compare channels and its register file.
`timescale 1ns/10ps
// What this block does
// - Prescale field bits 7:5 divides the system tick by 1 to 128.
// - Counter advances only while run bit 4 is set; otherwise holds.
// - Overflow interrupt request only when overflow mask bit 3 is one; resets one.
// - Writing one to clear bit 2 zeroes the counter; bit reads zero.
// - Mode 00 counts 0x00 up to 0xFF and wraps forever.
// - Mode 01 loads channel 0 compare value and counts down to 0x00.
// - Mode 10 counts up to channel 0 compare value then restarts.
// - Up/down mode counts up to channel 0 value then back down.
// - Channel compare actions happen only while its enable bit 2 is one.
// - Channel compare interrupt only when its mask bit 6 is one; resets one.
// - Match drives output high, low or toggles for codes 000, 001, 010.
// - Code 011 sets on up-match, clears at zero or down-match in up/down.
// - Code 100 clears on up-match, sets at zero or down-match in up/down.
// - Channel 0 code 101 sets on match, clears when counter reaches 0xFF.
// - Channel 0 code 110 clears on match, sets when counter reaches 0x00.
// - Channel 1 code 101 sets on match, clears at channel 0 value.
// - Channel 1 code 110 clears on match, sets at channel 0 value.
// - Each channel has an 8-bit read/write compare value resetting to 0x00.
// - Clearing the counter also forces the count direction upward.
// - New channel 0 value applies at count 0x00; channel 1 at once.
// - A compare match raises the channel flag, and interrupt when masked in.
// - Terminal count raises the overflow flag, and interrupt when masked in.
module timer8_compare (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic tick_en,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata_q,
    output logic [1:0] ch_out,
    output logic [1:0] ch_out_en,
    output logic terminal_count_flag,
    output logic [1:0] channel_compare_flag,
    output logic irq_req
);

    // =========================================================
    // Register file
    // =========================================================
    timer8_pkg::timer_ctrl_t ctrl_q;
    timer8_pkg::chan_ctrl_t cctl_q [2];
    logic [7:0] ccv_q [2];
    logic [7:0] cc0_act_q;
    // The counter is declared here because the compare shadow load below watches it.
    logic [7:0] cnt_q;

    timer8_pkg::timer_ctrl_t wctrl;
    assign wctrl = timer8_pkg::timer_ctrl_t'(sfr_wdata);

    // Address decode of writes.
    wire wr_ctrl = sfr_wr & (sfr_addr == timer8_pkg::ADDR_TIMER_CONTROL);
    wire wr_cctl0 = sfr_wr & (sfr_addr == timer8_pkg::ADDR_CH0_CONTROL);
    wire wr_ccv0 = sfr_wr & (sfr_addr == timer8_pkg::ADDR_CH0_VALUE);
    wire wr_cctl1 = sfr_wr & (sfr_addr == timer8_pkg::ADDR_CH1_CONTROL);
    wire wr_ccv1 = sfr_wr & (sfr_addr == timer8_pkg::ADDR_CH1_VALUE);
    wire clr_wr = wr_ctrl & sfr_wdata[timer8_pkg::CLEAR_BIT];
    // Down mode reloads when software starts a halted timer.
    wire down_load = wr_ctrl & wctrl.run & ~ctrl_q.run & (wctrl.mode == timer8_pkg::MODE_DOWN);

    // The clear bit is a strobe and is never stored.
    always_ff @(posedge clk_sys) begin
        if (!rstn) ctrl_q <= timer8_pkg::timer_ctrl_t'(timer8_pkg::RST_TIMER_CONTROL);
        else if (wr_ctrl) ctrl_q <= {wctrl.div, wctrl.run, wctrl.overflow_irq_mask, 1'b0, wctrl.mode};
    end

    // Channel controls keep bits 1:0 as written; bit 7 always stays zero.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cctl_q[0] <= timer8_pkg::chan_ctrl_t'(timer8_pkg::RST_CH_CONTROL);
            cctl_q[1] <= timer8_pkg::chan_ctrl_t'(timer8_pkg::RST_CH_CONTROL);
        end else begin
            if (wr_cctl0) cctl_q[0] <= timer8_pkg::chan_ctrl_t'({1'b0, sfr_wdata[6:0]});
            if (wr_cctl1) cctl_q[1] <= timer8_pkg::chan_ctrl_t'({1'b0, sfr_wdata[6:0]});
        end
    end

    // Compare values; channel 0 only reaches the comparators at count zero.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ccv_q[0] <= timer8_pkg::RST_CH_VALUE;
            ccv_q[1] <= timer8_pkg::RST_CH_VALUE;
            cc0_act_q <= timer8_pkg::RST_CH_VALUE;
        end else begin
            if (wr_ccv0) ccv_q[0] <= sfr_wdata;
            if (wr_ccv1) ccv_q[1] <= sfr_wdata;
            if (cnt_q == timer8_pkg::COUNT_ZERO) cc0_act_q <= ccv_q[0];
        end
    end

    // Read mux; unmapped addresses read as zero.
    logic [7:0] rd_mux;
    assign rd_mux = (sfr_addr == timer8_pkg::ADDR_TIMER_CONTROL) ? ctrl_q :
                    (sfr_addr == timer8_pkg::ADDR_CH0_CONTROL) ? cctl_q[0] :
                    (sfr_addr == timer8_pkg::ADDR_CH0_VALUE) ? ccv_q[0] :
                    (sfr_addr == timer8_pkg::ADDR_CH1_CONTROL) ? cctl_q[1] :
                    (sfr_addr == timer8_pkg::ADDR_CH1_VALUE) ? ccv_q[1] : 8'h00;

    // Read data is registered and valid the cycle after the strobe.
    always_ff @(posedge clk_sys) begin
        if (!rstn) sfr_rdata_q <= 8'h00;
        else if (sfr_rd) sfr_rdata_q <= rd_mux;
    end

    // =========================================================
    // Prescaler
    // =========================================================
    logic [timer8_pkg::PRESC_W-1:0] presc_q;
    logic [timer8_pkg::PRESC_W-1:0] div_mask;
    logic [7:0] div_full;
    assign div_full = (8'h01 << ctrl_q.div) - 8'h01;
    assign div_mask = div_full[timer8_pkg::PRESC_W-1:0];
    // An active edge is one tick in every 2**div ticks.
    wire active = tick_en & ((presc_q & div_mask) == div_mask);
    wire step = active & ctrl_q.run;

    always_ff @(posedge clk_sys) begin
        if (!rstn) presc_q <= '0;
        else if (clr_wr) presc_q <= '0;
        else if (tick_en) presc_q <= presc_q + 1'b1;
    end

    // =========================================================
    // Counter
    // =========================================================
    logic [7:0] cnt_d;
    logic [7:0] term;
    timer8_pkg::dir_t dir_q;
    timer8_pkg::dir_t dir_d;
    logic going_down;

    // Next count per mode; without a step the counter holds.
    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        going_down = 1'b0;
        term = timer8_pkg::COUNT_ZERO;
        unique case (ctrl_q.mode)
            timer8_pkg::MODE_FREE: begin
                term = timer8_pkg::COUNT_TOP;
                if (step) cnt_d = cnt_q + 8'h01;
            end
            timer8_pkg::MODE_DOWN: begin
                going_down = 1'b1;
                if (step && cnt_q != timer8_pkg::COUNT_ZERO) cnt_d = cnt_q - 8'h01;
            end
            timer8_pkg::MODE_MODULO: begin
                term = cc0_act_q;
                if (step) cnt_d = (cnt_q == cc0_act_q) ? timer8_pkg::COUNT_ZERO
                                                       : cnt_q + 8'h01;
            end
            timer8_pkg::MODE_UPDOWN: begin
                if (dir_q == timer8_pkg::DIR_UP && cnt_q >= cc0_act_q) begin
                    going_down = 1'b1;
                    if (step) begin
                        dir_d = timer8_pkg::DIR_DOWN;
                        if (cnt_q != timer8_pkg::COUNT_ZERO) cnt_d = cnt_q - 8'h01;
                    end
                end else if (dir_q == timer8_pkg::DIR_DOWN && cnt_q != timer8_pkg::COUNT_ZERO) begin
                    going_down = 1'b1;
                    if (step) cnt_d = cnt_q - 8'h01;
                end else if (step) begin
                    dir_d = timer8_pkg::DIR_UP;
                    cnt_d = cnt_q + 8'h01;
                end
            end
        endcase
    end

    // Clear beats a start load, which beats normal counting.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_q <= timer8_pkg::COUNT_ZERO;
            dir_q <= timer8_pkg::DIR_UP;
        end else if (clr_wr) begin
            cnt_q <= timer8_pkg::COUNT_ZERO;
            dir_q <= timer8_pkg::DIR_UP;
        end else if (down_load) begin
            cnt_q <= ccv_q[0];
            dir_q <= timer8_pkg::DIR_UP;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // Terminal count is reached when a step moves the counter onto it.
    wire moved = step & ~clr_wr & ~down_load & (cnt_d != cnt_q);
    wire ovf_evt = moved & (cnt_d == term);

    // =========================================================
    // Compare channels
    // =========================================================
    timer8_pkg::cnt_event_t ev;
    assign ev.step = moved;
    assign ev.down = going_down;
    assign ev.updown = (ctrl_q.mode == timer8_pkg::MODE_UPDOWN);
    assign ev.at_zero = (cnt_d == timer8_pkg::COUNT_ZERO);
    assign ev.at_top = (cnt_d == timer8_pkg::COUNT_TOP);
    assign ev.at_period = moved & (cnt_d == cc0_act_q);

    logic [1:0] ch_match;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            timer8_channel #(.IS_CH0(gi == 0)) u_ch (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .cfg(cctl_q[gi]),
                .ev(ev),
                .cnt_next(cnt_d),
                .cmp_value((gi == 0) ? cc0_act_q : ccv_q[1]),
                .match(ch_match[gi]),
                .pin_q(ch_out[gi])
            );
            assign ch_out_en[gi] = cctl_q[gi].enable;
        end
    endgenerate

    // =========================================================
    // Flags and interrupt request
    // =========================================================
    // Flag pulses go to the shared flag register; the request is already masked.
    wire irq_d = (ovf_evt & ctrl_q.overflow_irq_mask)
               | (ch_match[0] & cctl_q[0].channel_irq_mask)
               | (ch_match[1] & cctl_q[1].channel_irq_mask);

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            terminal_count_flag <= 1'b0;
            channel_compare_flag <= 2'h0;
            irq_req <= 1'b0;
        end else begin
            terminal_count_flag <= ovf_evt;
            channel_compare_flag <= ch_match;
            irq_req <= irq_d;
        end
    end

    // =========================================================
    // Assertions
    // =========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_halt_holds_count: assert property (!ctrl_q.run && !clr_wr && !down_load |=> $stable(cnt_q))
        else $error("Counter moved while halted.");
    a_clear_zero_up: assert property (clr_wr |=> cnt_q == 8'h00 && dir_q == timer8_pkg::DIR_UP)
        else $error("Clear did not zero the counter upward.");
    a_step_needs_tick: assert property (step |-> tick_en && ctrl_q.run)
        else $error("Counter step without tick.");
    a_free_wraps: assert property (step && !wr_ctrl && ctrl_q.mode == timer8_pkg::MODE_FREE
        && cnt_q == 8'hff |=> cnt_q == 8'h00 ##0 terminal_count_flag == 1'b0)
        else $error("Free mode did not wrap.");
    a_modulo_restart: assert property (step && !wr_ctrl && ctrl_q.mode == timer8_pkg::MODE_MODULO
        && cnt_q == cc0_act_q |=> cnt_q == 8'h00)
        else $error("Modulo mode did not restart.");
    a_down_stops: assert property (!wr_ctrl && ctrl_q.mode == timer8_pkg::MODE_DOWN
        && cnt_q == 8'h00 |=> cnt_q == 8'h00)
        else $error("Down mode passed zero.");
    a_ovf_irq_gate: assert property (ovf_evt && ctrl_q.overflow_irq_mask |=> irq_req && terminal_count_flag)
        else $error("Overflow request missing.");
    a_shadow_hold: assert property (cnt_q != 8'h00 |=> cc0_act_q == $past(cc0_act_q))
        else $error("Channel 0 value applied away from zero.");
    a_disabled_pin: assert property (!cctl_q[0].enable |=> ch_out[0] == $past(ch_out[0]))
        else $error("Disabled channel pin moved.");
    a_clear_reads_zero: assert property (sfr_rd && sfr_addr == timer8_pkg::ADDR_TIMER_CONTROL
        |=> sfr_rdata_q[2] == 1'b0)
        else $error("Clear bit read back as one.");
    a_match_flag: assert property (ch_match[1] |=> channel_compare_flag[1] ##1 !channel_compare_flag[1] || ch_match[1])
        else $error("Compare flag pulse wrong.");

    c_free_wrap: cover property (ovf_evt && ctrl_q.mode == timer8_pkg::MODE_FREE);
    c_updown_turn: cover property (step && dir_q == timer8_pkg::DIR_UP && dir_d == timer8_pkg::DIR_DOWN);
    c_pwm_toggle: cover property (ch_match[0] ##[1:300] ch_match[0]);
    c_ch1_irq: cover property (ch_match[1] && cctl_q[1].channel_irq_mask);

endmodule

// ===== timer8_pkg.sv
// Package with the register map, field layouts and shared types of the 8-bit compare timer.
package timer8_pkg;

    // =========================================================
    // Register addresses on the special function register port
    // =========================================================
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hcb;
    localparam logic [7:0] ADDR_CH0_CONTROL = 8'hcc;
    localparam logic [7:0] ADDR_CH0_VALUE = 8'hcd;
    localparam logic [7:0] ADDR_CH1_CONTROL = 8'hce;
    localparam logic [7:0] ADDR_CH1_VALUE = 8'hcf;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h08;
    localparam logic [7:0] RST_CH_CONTROL = 8'h40;
    localparam logic [7:0] RST_CH_VALUE = 8'h00;

    // =========================================================
    // Counter constants and mode codes
    // =========================================================
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hff;
    localparam logic [1:0] MODE_FREE = 2'h0;
    localparam logic [1:0] MODE_DOWN = 2'h1;
    localparam logic [1:0] MODE_MODULO = 2'h2;
    localparam logic [1:0] MODE_UPDOWN = 2'h3;
    localparam int CLEAR_BIT = 2;
    localparam int PRESC_W = 7;

    // =========================================================
    // Compare action codes
    // =========================================================
    localparam logic [2:0] ACT_SET = 3'h0;
    localparam logic [2:0] ACT_CLEAR = 3'h1;
    localparam logic [2:0] ACT_TOGGLE = 3'h2;
    localparam logic [2:0] ACT_SET_UP = 3'h3;
    localparam logic [2:0] ACT_CLEAR_UP = 3'h4;
    localparam logic [2:0] ACT_SET_PERIOD = 3'h5;
    localparam logic [2:0] ACT_CLEAR_PERIOD = 3'h6;

    // =========================================================
    // Register layouts, most significant field first
    // =========================================================
    typedef struct packed {
        logic [2:0] div;
        logic run;
        logic overflow_irq_mask;
        logic counter_clear;
        logic [1:0] mode;
    } timer_ctrl_t;

    typedef struct packed {
        logic unused;
        logic channel_irq_mask;
        logic [2:0] compare_action_select;
        logic enable;
        logic [1:0] reserved;
    } chan_ctrl_t;

    // Per-step counter events handed to each channel.
    typedef struct packed {
        logic step;
        logic down;
        logic updown;
        logic at_zero;
        logic at_top;
        logic at_period;
    } cnt_event_t;

    typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

endpackage

// ===== timer8_channel.sv
// One compare channel: match detection and the registered output pin.
`timescale 1ns/10ps
module timer8_channel #(
    parameter bit IS_CH0 = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire timer8_pkg::chan_ctrl_t cfg,
    input wire timer8_pkg::cnt_event_t ev,
    input wire logic [7:0] cnt_next,
    input wire logic [7:0] cmp_value,
    output logic match,
    output logic pin_q
);

    // =========================================================
    // Event decode
    // =========================================================
    // A match needs an active step onto the compare value with compare enabled.
    assign match = cfg.enable & ev.step & (cnt_next == cmp_value);
    wire up_match = match & ~ev.down;
    wire down_match = match & ev.down;
    wire zero_hit = cfg.enable & ev.step & ev.at_zero & ~ev.updown;
    // Channel 0 ends its period at the top value, channel 1 at the channel 0 period.
    wire period_hit = cfg.enable & (IS_CH0 ? (ev.step & ev.at_top) : ev.at_period);

    logic pin_d;

    // Next pin level; a match always wins over the period end in the same step.
    always_comb begin
        pin_d = pin_q;
        unique case (cfg.compare_action_select)
            timer8_pkg::ACT_SET: if (match) pin_d = 1'b1;
            timer8_pkg::ACT_CLEAR: if (match) pin_d = 1'b0;
            timer8_pkg::ACT_TOGGLE: if (match) pin_d = ~pin_q;
            timer8_pkg::ACT_SET_UP: begin
                if (up_match) pin_d = 1'b1;
                else if (ev.updown ? down_match : zero_hit) pin_d = 1'b0;
            end
            timer8_pkg::ACT_CLEAR_UP: begin
                if (up_match) pin_d = 1'b0;
                else if (ev.updown ? down_match : zero_hit) pin_d = 1'b1;
            end
            timer8_pkg::ACT_SET_PERIOD: begin
                if (match) pin_d = 1'b1;
                else if (period_hit) pin_d = 1'b0;
            end
            timer8_pkg::ACT_CLEAR_PERIOD: begin
                if (match) pin_d = 1'b0;
                else if (IS_CH0 ? (zero_hit | (cfg.enable & ev.step & ev.at_zero)) : period_hit)
                    pin_d = 1'b1;
            end
            default: pin_d = pin_q;
        endcase
    end

    // The pin comes straight from a flop so that its edges cannot glitch.
    always_ff @(posedge clk_sys) begin
        if (!rstn) pin_q <= 1'b0;
        else pin_q <= pin_d;
    end

endmodule

// ===== testbench.sv
// Self-checking testbench for the 8-bit timer with two output-compare channels.
`timescale 1ns/10ps
module testbench;
    // ==========================================================
    // Signals
    // ==========================================================
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic tick_en = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata_q;
    logic [1:0] ch_out;
    logic [1:0] ch_out_en;
    logic terminal_count_flag;
    logic [1:0] channel_compare_flag;
    logic irq_req;
    logic tick_half = 1'b0;
    int n_errors = 0;
    int num_checks = 0;

    // ==========================================================
    // Clock, tick and device
    // ==========================================================
    // The tick either stays high or pulses every other cycle, so the prescaler sees both.
    always #4 clk_sys = ~clk_sys;
    always @(negedge clk_sys) tick_en <= tick_half ? ~tick_en : 1'b1;

    timer8_compare dut (.clk_sys(clk_sys), .rstn(rstn), .tick_en(tick_en),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata_q(sfr_rdata_q), .ch_out(ch_out), .ch_out_en(ch_out_en),
        .terminal_count_flag(terminal_count_flag),
        .channel_compare_flag(channel_compare_flag), .irq_req(irq_req));

    // ==========================================================
    // Helpers
    // ==========================================================
    // Every comparison is counted; a mismatch prints at once.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Strobes rise at a falling edge and fall one cycle later, so one rising edge takes them.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        chk(what, {8'h00, exp}, {8'h00, sfr_rdata_q});
    endtask

    task automatic set_ctl(input logic [2:0] dv, input logic r, m, c, input logic [1:0] md);
        wr(timer8_pkg::ADDR_TIMER_CONTROL, {dv, r, m, c, md});
    endtask

    task automatic set_ch(input int c, input logic im, input logic [2:0] act, input logic en);
        wr(c == 0 ? timer8_pkg::ADDR_CH0_CONTROL : timer8_pkg::ADDR_CH1_CONTROL,
            {1'b0, im, act, en, 2'b00});
    endtask

    // Counts cycles up to an event pulse: 0 overflow, 1 and 2 channels, 3 interrupt.
    task automatic wait_ev(input int k, input int lim, input bit must, output int n);
        logic [3:0] all;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
            all = {irq_req, channel_compare_flag, terminal_count_flag};
        end while (all[k] !== 1'b1 && n < lim);
        if (must && all[k] !== 1'b1) begin
            n_errors++;
            $display("ERROR event %0d expected within %0d seen none", k, lim);
            results();
        end
    endtask

    // Measures one whole high pulse of a channel pin, skipping any pulse already under way.
    task automatic pin_len(input int c, output int n);
        int w;
        for (w = 0; w < 600 && ch_out[c] !== 1'b0; w++) @(negedge clk_sys);
        for (w = 0; w < 600 && ch_out[c] !== 1'b1; w++) @(negedge clk_sys);
        for (n = 0; n < 600 && ch_out[c] === 1'b1; n++) @(negedge clk_sys);
        if (n == 0 || n == 600) begin
            n_errors++;
            $display("ERROR pin %0d pulse expected seen none", c);
            results();
        end
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_regs();
        chk("pin enable", 16'h0000, {14'h0000, ch_out_en});
        rd_chk("control", timer8_pkg::ADDR_TIMER_CONTROL, 8'h08);
        rd_chk("ch0 control", timer8_pkg::ADDR_CH0_CONTROL, 8'h40);
        rd_chk("ch1 control", timer8_pkg::ADDR_CH1_CONTROL, 8'h40);
        rd_chk("ch0 value", timer8_pkg::ADDR_CH0_VALUE, 8'h00);
        rd_chk("ch1 value", timer8_pkg::ADDR_CH1_VALUE, 8'h00);
        wr(timer8_pkg::ADDR_CH0_CONTROL, 8'hd0);
        rd_chk("ch0 control", timer8_pkg::ADDR_CH0_CONTROL, 8'h50);
        wr(timer8_pkg::ADDR_TIMER_CONTROL, 8'hec);
        rd_chk("control", timer8_pkg::ADDR_TIMER_CONTROL, 8'he8);
        wr(timer8_pkg::ADDR_CH1_VALUE, 8'ha5);
        rd_chk("ch1 value", timer8_pkg::ADDR_CH1_VALUE, 8'ha5);
        wr(8'hca, 8'h5a);
        rd_chk("unmapped", 8'hca, 8'h00);
        set_ch(0, 1'b1, timer8_pkg::ACT_SET, 1'b0);
    endtask

    task automatic t_free();
        int n;
        for (int d = 0; d < 6; d += 2) begin
            set_ctl(d[2:0], 1'b1, 1'b1, 1'b1, timer8_pkg::MODE_FREE);
            wait_ev(0, 40000, 1'b1, n);
            wait_ev(0, 40000, 1'b1, n);
            chk("free period", 16'h0100 << d, n[15:0]);
            chk("overflow irq", 16'h0001, {15'h0000, irq_req});
        end
        tick_half = 1'b1;
        set_ctl(3'h0, 1'b1, 1'b0, 1'b1, timer8_pkg::MODE_FREE);
        wait_ev(0, 2000, 1'b1, n);
        wait_ev(0, 2000, 1'b1, n);
        chk("half tick period", 16'h0200, n[15:0]);
        chk("masked overflow irq", 16'h0000, {15'h0000, irq_req});
        tick_half = 1'b0;
        set_ctl(3'h0, 1'b1, 1'b0, 1'b1, timer8_pkg::MODE_FREE);
        wait_ev(0, 600, 1'b1, n);
        set_ctl(3'h0, 1'b0, 1'b0, 1'b0, timer8_pkg::MODE_FREE);
        wait_ev(0, 600, 1'b0, n);
        chk("halted", 16'h0258, n[15:0]);
        set_ctl(3'h0, 1'b1, 1'b0, 1'b0, timer8_pkg::MODE_FREE);
        wait_ev(0, 600, 1'b1, n);
        chk("resumed", 16'h00fe, n[15:0]);
    endtask

    task automatic t_modes();
        int n;
        wr(timer8_pkg::ADDR_CH0_VALUE, 8'h09);
        set_ctl(3'h0, 1'b1, 1'b0, 1'b1, timer8_pkg::MODE_MODULO);
        wait_ev(0, 300, 1'b1, n);
        wr(timer8_pkg::ADDR_CH0_VALUE, 8'h13);
        wait_ev(0, 300, 1'b1, n);
        chk("modulo old period", 16'h0008, n[15:0]);
        wait_ev(0, 300, 1'b1, n);
        chk("modulo new period", 16'h0014, n[15:0]);
        wr(timer8_pkg::ADDR_CH0_VALUE, 8'h05);
        set_ctl(3'h0, 1'b0, 1'b0, 1'b1, timer8_pkg::MODE_DOWN);
        set_ctl(3'h0, 1'b1, 1'b1, 1'b0, timer8_pkg::MODE_DOWN);
        wait_ev(0, 300, 1'b1, n);
        chk("down length", 16'h0005, n[15:0]);
        chk("down irq", 16'h0001, {15'h0000, irq_req});
        wait_ev(0, 300, 1'b0, n);
        chk("down holds", 16'h012c, n[15:0]);
        wr(timer8_pkg::ADDR_CH0_VALUE, 8'h04);
        wr(timer8_pkg::ADDR_CH1_VALUE, 8'h01);
        set_ch(1, 1'b0, timer8_pkg::ACT_SET_UP, 1'b1);
        set_ctl(3'h0, 1'b1, 1'b0, 1'b1, timer8_pkg::MODE_UPDOWN);
        wait_ev(0, 300, 1'b1, n);
        wait_ev(0, 300, 1'b1, n);
        chk("updown period", 16'h0008, n[15:0]);
        pin_len(1, n);
        chk("set up pulse", 16'h0006, n[15:0]);
        set_ch(1, 1'b0, timer8_pkg::ACT_CLEAR_UP, 1'b1);
        pin_len(1, n);
        chk("clear up pulse", 16'h0002, n[15:0]);
    endtask

    task automatic t_compare();
        int n;
        logic [2:0] acts [4] = '{timer8_pkg::ACT_SET, timer8_pkg::ACT_CLEAR,
            timer8_pkg::ACT_TOGGLE, timer8_pkg::ACT_TOGGLE};
        logic [3:0] pin_exp = 4'h5;
        wr(timer8_pkg::ADDR_CH1_VALUE, 8'h40);
        set_ctl(3'h0, 1'b1, 1'b0, 1'b1, timer8_pkg::MODE_FREE);
        for (int i = 0; i < 4; i++) begin
            set_ch(1, i < 3, acts[i], 1'b1);
            wait_ev(2, 300, 1'b1, n);
            chk("ch1 pin", {15'h0000, pin_exp[i]}, {15'h0000, ch_out[1]});
            chk("ch1 irq", {15'h0000, i < 3}, {15'h0000, irq_req});
            chk("pin enable", 16'h0002, {14'h0000, ch_out_en});
        end
        set_ch(1, 1'b1, timer8_pkg::ACT_SET, 1'b0);
        wait_ev(2, 300, 1'b0, n);
        chk("disabled no match", 16'h012c, n[15:0]);
        chk("disabled pin", 16'h0000, {15'h0000, ch_out[1]});
        wr(timer8_pkg::ADDR_CH0_VALUE, 8'h10);
        set_ch(0, 1'b0, timer8_pkg::ACT_SET_PERIOD, 1'b1);
        pin_len(0, n);
        chk("ch0 set pulse", 16'h00ef, n[15:0]);
        set_ch(0, 1'b0, timer8_pkg::ACT_CLEAR_PERIOD, 1'b1);
        pin_len(0, n);
        chk("ch0 clear pulse", 16'h0010, n[15:0]);
        wait_ev(1, 300, 1'b1, n);
        chk("ch0 pin at match", 16'h0000, {15'h0000, ch_out[0]});
        chk("ch0 masked irq", 16'h0000, {15'h0000, irq_req});
        wr(timer8_pkg::ADDR_CH0_VALUE, 8'h09);
        wr(timer8_pkg::ADDR_CH1_VALUE, 8'h03);
        set_ch(1, 1'b0, timer8_pkg::ACT_SET_PERIOD, 1'b1);
        set_ctl(3'h0, 1'b1, 1'b0, 1'b1, timer8_pkg::MODE_MODULO);
        pin_len(1, n);
        chk("ch1 set pulse", 16'h0006, n[15:0]);
        set_ch(1, 1'b0, timer8_pkg::ACT_CLEAR_PERIOD, 1'b1);
        pin_len(1, n);
        chk("ch1 clear pulse", 16'h0004, n[15:0]);
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        t_regs();
        t_free();
        t_modes();
        t_compare();
        results();
    end
endmodule
